// ==== hdl/vid_dispatch.sv ====
// Interrupt mode select, priority encoding and external-controller handshake
`timescale 1ns/1ns
module vid_dispatch (
    input  wire logic                          core_clk,
    input  wire logic                          resetn,
    input  wire logic [7:0]                    paddr,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [31:0]                   pwdata,
    output logic      [31:0]                   prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic [5:0]                    hw_request_lines,
    input  wire logic                          ext_ctrl_mode_supported,
    input  wire logic                          timer_request,
    input  wire logic                          perf_counter_request,
    input  wire logic                          debug_channel_request,
    input  wire logic [vid_pkg::VID_SS_W-1:0]  ext_supplied_shadow_set,
    input  wire logic                          exception_start,
    output logic                               irq_to_pipeline,
    output logic [5:0]                         vector_number,
    output logic [15:0]                        vector_offset,
    output logic [vid_pkg::VID_SS_W-1:0]       current_shadow_set,
    output logic [1:0]                         soft_request_out,
    output logic                               timer_request_out,
    output logic                               perf_counter_request_out,
    output logic                               debug_channel_request_out,
    output logic                               service_ack,
    output vid_pkg::vid_mode_t                 irq_mode
);
    import vid_pkg::*;

    // ------------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------------
    function automatic logic [2:0] prio_encode(input logic [7:0] req);
        prio_encode = 3'h0;
        for (int i = 0; i < 8; i++) begin
            if (req[i]) begin
                prio_encode = i[2:0];
            end
        end
    endfunction : prio_encode

    function automatic logic [15:0] vec_offset(input logic [5:0] vec,
                                               input logic [4:0] vs);
        logic [15:0] spacing;
        spacing    = {6'h00, vs, 5'h00};
        vec_offset = VID_BASE_OFFSET + 16'(vec * spacing);
    endfunction : vec_offset

    // ------------------------------------------------------------------
    // Software visible state
    // ------------------------------------------------------------------
    logic                 ie_r;
    logic                 exl_r;
    logic                 erl_r;
    logic                 bev_r;
    logic [7:0]           im_r;
    logic                 iv_r;
    logic [1:0]           sw_ip_r;
    logic [VID_LVL_W-1:0] requested_priority_level_r;
    logic [VID_VS_W-1:0]  vs_r;
    logic                 vectored_mode_supported_r;
    logic [2:0]           tix_r;
    logic [2:0]           pcix_r;
    logic [2:0]           fdcx_r;
    logic [VID_SS_W-1:0]  ext_supplied_shadow_set_r;
    logic [VID_SS_W-1:0]  css_r;
    logic [VID_SS_W-1:0]  map_rd;

    logic apb_wr;
    logic apb_rd;
    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;

    // ------------------------------------------------------------------
    // Mode select
    // ------------------------------------------------------------------
    logic vec_en;
    logic ext_en;
    vid_mode_t mode_nxt;
    always_comb begin
        vec_en = !bev_r && iv_r && (vs_r != '0);
        if (vec_en && ext_ctrl_mode_supported) begin
            mode_nxt = VID_MODE_EXT;
        end else if (vec_en && vectored_mode_supported_r) begin
            mode_nxt = VID_MODE_VEC;
        end else begin
            mode_nxt = VID_MODE_COMPAT;
        end
        ext_en = (mode_nxt == VID_MODE_EXT);
    end

    // ------------------------------------------------------------------
    // Request evaluation
    // ------------------------------------------------------------------
    logic [7:0]           pend_bits;
    logic [7:0]           masked;
    logic                 enabled;
    logic                 vec_irq;
    logic                 ext_irq;
    logic [2:0]           vec_num;
    logic [VID_LVL_W-1:0] current_priority_level;
    always_comb begin
        pend_bits = {hw_request_lines, sw_ip_r};
        masked    = pend_bits & im_r;
        enabled   = ie_r && !exl_r && !erl_r;
        vec_irq   = (masked != 8'h00) && enabled;
        vec_num   = prio_encode(masked);
        current_priority_level       = im_r[7:2];
        ext_irq   = (hw_request_lines > current_priority_level) && enabled;
    end

    logic take_ext;
    logic take_vec;
    assign take_ext = (irq_mode == VID_MODE_EXT) && irq_to_pipeline && exception_start;
    assign take_vec = (irq_mode == VID_MODE_VEC) && irq_to_pipeline && exception_start;

    // ------------------------------------------------------------------
    // Status register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            ie_r  <= VID_STATUS_RST[VID_ST_IE];
            exl_r <= VID_STATUS_RST[VID_ST_EXL];
            erl_r <= VID_STATUS_RST[VID_ST_ERL];
            bev_r <= VID_STATUS_RST[VID_ST_BEV];
            im_r  <= VID_STATUS_RST[VID_ST_IM +: 8];
        end else if (exception_start && irq_to_pipeline) begin
            exl_r <= 1'b1;
        end else if (apb_wr && paddr == VID_OFF_STATUS) begin
            ie_r  <= pwdata[VID_ST_IE];
            exl_r <= pwdata[VID_ST_EXL];
            erl_r <= pwdata[VID_ST_ERL];
            bev_r <= pwdata[VID_ST_BEV];
            im_r  <= pwdata[VID_ST_IM +: 8];
        end
    end

    // ------------------------------------------------------------------
    // Cause register and captured level
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            iv_r    <= 1'b0;
            sw_ip_r <= 2'h0;
        end else if (apb_wr && paddr == VID_OFF_CAUSE) begin
            iv_r    <= pwdata[VID_CA_IV];
            sw_ip_r <= pwdata[VID_CA_IP +: 2];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            requested_priority_level_r  <= '0;
            ext_supplied_shadow_set_r <= '0;
        end else if (take_ext) begin
            requested_priority_level_r  <= hw_request_lines;
            ext_supplied_shadow_set_r <= ext_supplied_shadow_set;
        end
    end

    // ------------------------------------------------------------------
    // Control, capability and shadow control
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            vs_r   <= '0;
            tix_r  <= VID_TIX_RST;
            pcix_r <= VID_PCIX_RST;
            fdcx_r <= VID_FDCX_RST;
        end else if (apb_wr && paddr == VID_OFF_CTRL) begin
            vs_r   <= pwdata[VID_CT_VS +: VID_VS_W];
            tix_r  <= pwdata[VID_CT_TIX +: 3];
            pcix_r <= pwdata[VID_CT_PCIX +: 3];
            fdcx_r <= pwdata[VID_CT_FDCX +: 3];
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            vectored_mode_supported_r <= 1'b1;
        end else if (apb_wr && paddr == VID_OFF_CAP) begin
            vectored_mode_supported_r <= pwdata[VID_CP_VECTORED_MODE_SUPPORTED];
        end
    end

    vid_shadow_map u_map (
        .core_clk (core_clk),
        .resetn   (resetn),
        .wr_en    (apb_wr && paddr == VID_OFF_SSMAP),
        .wr_addr  (pwdata[6:4]),
        .wr_data  (pwdata[VID_SS_W-1:0]),
        .rd_addr  (vec_num),
        .rd_data  (map_rd)
    );

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            css_r <= '0;
        end else if (take_ext) begin
            css_r <= ext_supplied_shadow_set;
        end else if (take_vec) begin
            css_r <= map_rd;
        end else if (apb_wr && paddr == VID_OFF_SHADOW) begin
            css_r <= pwdata[VID_SS_W-1:0];
        end
    end
    assign current_shadow_set = css_r;

    // ------------------------------------------------------------------
    // Dispatch outputs
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            irq_mode        <= VID_MODE_COMPAT;
            irq_to_pipeline <= 1'b0;
            vector_number   <= '0;
            vector_offset   <= VID_BASE_OFFSET;
            service_ack     <= 1'b0;
        end else begin
            irq_mode    <= mode_nxt;
            service_ack <= take_ext;
            unique case (mode_nxt)
                VID_MODE_VEC: begin
                    irq_to_pipeline <= vec_irq && !(exception_start && irq_to_pipeline);
                    vector_number   <= {3'h0, vec_num};
                    vector_offset   <= vec_offset({3'h0, vec_num}, vs_r);
                end
                VID_MODE_EXT: begin
                    irq_to_pipeline <= ext_irq && !(exception_start && irq_to_pipeline);
                    vector_number   <= take_ext ? hw_request_lines : requested_priority_level_r;
                    vector_offset   <= vec_offset(take_ext ? hw_request_lines : requested_priority_level_r,
                                                  vs_r);
                end
                VID_MODE_COMPAT: begin
                    irq_to_pipeline <= vec_irq;
                    vector_number   <= '0;
                    vector_offset   <= VID_BASE_OFFSET;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Requests forwarded to the external controller
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            soft_request_out          <= 2'h0;
            timer_request_out         <= 1'b0;
            perf_counter_request_out  <= 1'b0;
            debug_channel_request_out <= 1'b0;
        end else begin
            soft_request_out          <= ext_en ? sw_ip_r : 2'h0;
            timer_request_out         <= timer_request;
            perf_counter_request_out  <= perf_counter_request;
            debug_channel_request_out <= debug_channel_request;
        end
    end

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    logic [31:0] rd_word;
    logic        rd_bad;
    always_comb begin
        rd_word = VID_ZERO_WORD;
        rd_bad  = 1'b0;
        unique case (paddr)
            VID_OFF_STATUS: begin
                rd_word[VID_ST_IE]      = ie_r;
                rd_word[VID_ST_EXL]     = exl_r;
                rd_word[VID_ST_ERL]     = erl_r;
                rd_word[VID_ST_BEV]     = bev_r;
                rd_word[VID_ST_IM +: 8] = im_r;
            end
            VID_OFF_CAUSE: begin
                rd_word[VID_CA_IV]       = iv_r;
                rd_word[VID_CA_TI]       = timer_request;
                rd_word[VID_CA_PCI]      = perf_counter_request;
                rd_word[VID_CA_DEBUG_CHANNEL_REQUEST]     = debug_channel_request;
                rd_word[VID_CA_IP +: 2]  = sw_ip_r;
                rd_word[VID_CA_REQUESTED_PRIORITY_LEVEL +: 6] = ext_en ? requested_priority_level_r : hw_request_lines;
            end
            VID_OFF_CTRL: begin
                rd_word[VID_CT_VS +: VID_VS_W] = vs_r;
                rd_word[VID_CT_TIX +: 3]       = tix_r;
                rd_word[VID_CT_PCIX +: 3]      = pcix_r;
                rd_word[VID_CT_FDCX +: 3]      = fdcx_r;
            end
            VID_OFF_CAP: begin
                rd_word[VID_CP_VECTORED_MODE_SUPPORTED] = vectored_mode_supported_r;
                rd_word[VID_CP_EXT_CTRL_MODE_SUPPORTED] = ext_ctrl_mode_supported;
            end
            VID_OFF_DISPATCH: begin
                rd_word = {4'h0, irq_to_pipeline, irq_mode, vector_offset, 2'h0, vector_number};
            end
            VID_OFF_SHADOW: begin
                rd_word = {24'h000000, ext_supplied_shadow_set_r, css_r};
            end
            VID_OFF_SSMAP: begin
                rd_word = {28'h0000000, map_rd};
            end
            default: begin
                rd_bad = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            prdata  <= VID_ZERO_WORD;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && rd_bad;
            if (apb_rd) begin
                prdata <= rd_word;
            end
        end
    end

endmodule : vid_dispatch

// ==== hdl/vid_pkg.sv ====
// Constants and types for the vectored interrupt dispatch block
package vid_pkg;

    // ------------------------------------------------------------------
    // Register map (APB, byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] VID_OFF_STATUS   = 8'h00;
    localparam logic [7:0] VID_OFF_CAUSE    = 8'h04;
    localparam logic [7:0] VID_OFF_CTRL     = 8'h08;
    localparam logic [7:0] VID_OFF_CAP      = 8'h0c;
    localparam logic [7:0] VID_OFF_DISPATCH = 8'h10;
    localparam logic [7:0] VID_OFF_SHADOW   = 8'h14;
    localparam logic [7:0] VID_OFF_SSMAP    = 8'h18;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    // Status word
    localparam int VID_ST_IE   = 0;
    localparam int VID_ST_EXL  = 1;
    localparam int VID_ST_ERL  = 2;
    localparam int VID_ST_BEV  = 22;
    localparam int VID_ST_IM   = 8;
    localparam int VID_ST_IPL  = 10;
    // Cause word
    localparam int VID_CA_IP   = 8;
    localparam int VID_CA_REQUESTED_PRIORITY_LEVEL = 10;
    localparam int VID_CA_IV   = 23;
    localparam int VID_CA_PCI  = 26;
    localparam int VID_CA_DEBUG_CHANNEL_REQUEST = 21;
    localparam int VID_CA_TI   = 30;
    // Control word
    localparam int VID_CT_VS   = 5;
    localparam int VID_CT_PCIX = 26;
    localparam int VID_CT_FDCX = 23;
    localparam int VID_CT_TIX  = 29;
    // Capability word
    localparam int VID_CP_VECTORED_MODE_SUPPORTED = 5;
    localparam int VID_CP_EXT_CTRL_MODE_SUPPORTED = 6;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int          VID_LVL_W       = 6;
    localparam int          VID_VS_W        = 5;
    localparam int          VID_SS_W        = 4;
    localparam logic [31:0] VID_STATUS_RST  = 32'h0040_0004;
    localparam logic [31:0] VID_ZERO_WORD   = 32'h0000_0000;
    localparam logic [15:0] VID_BASE_OFFSET = 16'h0200;
    localparam logic [2:0]  VID_TIX_RST     = 3'h7;
    localparam logic [2:0]  VID_PCIX_RST    = 3'h6;
    localparam logic [2:0]  VID_FDCX_RST    = 3'h5;

    typedef enum logic [2:0] {
        VID_MODE_COMPAT = 3'b001,
        VID_MODE_VEC    = 3'b010,
        VID_MODE_EXT    = 3'b100
    } vid_mode_t;

endpackage : vid_pkg

// ==== hdl/vid_shadow_map.sv ====
// Small memory of shadow-set numbers, one per vector
`timescale 1ns/1ns
module vid_shadow_map (
    input  wire logic                   core_clk,
    input  wire logic                   resetn,
    input  wire logic                   wr_en,
    input  wire logic [2:0]             wr_addr,
    input  wire logic [vid_pkg::VID_SS_W-1:0] wr_data,
    input  wire logic [2:0]             rd_addr,
    output logic      [vid_pkg::VID_SS_W-1:0] rd_data
);
    import vid_pkg::*;

    logic [VID_SS_W-1:0] mem_r [0:7];

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            for (int i = 0; i < 8; i++) begin
                mem_r[i] <= '0;
            end
        end else if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem_r[rd_addr];
        end
    end

endmodule : vid_shadow_map

// ==== tb/testbench.sv ====
// Self-checking bench for the interrupt dispatch block
`timescale 1ns/1ns
module testbench;
    import vid_pkg::*;
    typedef struct packed {logic [3:0] kind; logic [31:0] val;} vid_exp_t;
    logic core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0] paddr = '0, ip, im;
    logic [31:0] pwdata = '0, prdata;
    logic [5:0] hw_request_lines, vector_number, lvl_in = '0, lvs [6], ps [6];
    logic ext_ctrl_mode_supported = 0, timer_request = 0, perf_counter_request = 0;
    logic debug_channel_request = 0, exception_start = 0, load = 0, probe_en = 0, ie;
    logic irq_to_pipeline, timer_request_out, perf_counter_request_out;
    logic debug_channel_request_out, service_ack;
    logic [3:0] ext_supplied_shadow_set, current_shadow_set, set_in = '0;
    logic [15:0] vector_offset;
    logic [1:0] soft_request_out;
    logic [4:0] vs;
    logic [2:0] v, fw;
    vid_mode_t irq_mode;
    vid_exp_t exp_q [$];
    vid_exp_t e;
    int num_errors = 0, num_checks = 0, seed = 98, i, j;

    always #20 core_clk = ~core_clk;

    vid_dispatch dut (.core_clk, .resetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .hw_request_lines, .ext_ctrl_mode_supported, .timer_request,
        .perf_counter_request, .debug_channel_request, .ext_supplied_shadow_set,
        .exception_start, .irq_to_pipeline, .vector_number, .vector_offset,
        .current_shadow_set, .soft_request_out, .timer_request_out, .perf_counter_request_out,
        .debug_channel_request_out, .service_ack, .irq_mode);
    vid_eic_model u_eic (.core_clk, .resetn, .ext_mode(ext_ctrl_mode_supported), .load,
        .lvl_in, .set_in, .service_ack, .hw_request_lines, .ext_supplied_shadow_set);

    task check_out(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_out

    task check_reg(input logic [31:0] got, input logic [31:0] exp);
        check_out(got, exp);
    endtask : check_reg

    task finish_test;
        $display("Checks %0d, errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge core_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) num_errors++;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rd(input logic [7:0] a, input logic [31:0] exp, input logic [3:0] k);
        exp_q.push_back({k, exp});
        apb(1'b0, a, 32'h0);
    endtask : rd

    task probe(input logic [3:0] k, input logic [31:0] exp);
        @(posedge core_clk);
        exp_q.push_back({k, exp});
        probe_en <= 1'b1;
        @(posedge core_clk);
        probe_en <= 1'b0;
    endtask : probe

    // ------------------------------------------------------------------
    // Result watcher: oldest note against each result seen
    // ------------------------------------------------------------------
    always @(posedge core_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = exp_q.pop_front();
            if (e.kind == 4'h8) check_reg({31'h0, pslverr}, 32'h1);
            else check_reg(prdata, e.val);
        end
        if (service_ack !== 1'b0) begin
            e = exp_q.pop_front();
            check_out({26'h0, vector_number}, e.val);
        end
        if (probe_en) begin
            e = exp_q.pop_front();
            case (e.kind)
                4'h0: check_out({29'h0, irq_mode}, e.val);
                4'h1: check_out({31'h0, irq_to_pipeline}, e.val);
                4'h2: check_out({26'h0, vector_number}, e.val);
                4'h3: check_out({16'h0, vector_offset}, e.val);
                4'h4: check_out({30'h0, soft_request_out}, e.val);
                4'h5: check_out({29'h0, timer_request_out, perf_counter_request_out,
                                 debug_channel_request_out}, e.val);
                default: check_out({28'h0, current_shadow_set}, e.val);
            endcase
        end
    end

    initial begin
        #400000;
        num_errors++;
        finish_test();
    end

    initial begin
        lvs = '{6'd5, 6'd3, 6'd63, 6'd0, 6'd1, 6'd20};
        ps  = '{6'd3, 6'd3, 6'd62, 6'd0, 6'd0, 6'd40};
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        rd(VID_OFF_STATUS, VID_STATUS_RST, 4'h7);
        rd(8'h1c, 32'h0, 4'h8);
        probe(4'h0, VID_MODE_COMPAT);
        $display("Test reset done");
        apb(1'b1, VID_OFF_CTRL, 32'h20);
        apb(1'b1, VID_OFF_CAUSE, 32'h0080_0000);
        apb(1'b1, VID_OFF_STATUS, 32'hff01);
        probe(4'h0, VID_MODE_VEC);
        for (i = 0; i < 12; i++) begin
            ip = $random(seed); im = $random(seed); ie = $random(seed); vs = $random(seed);
            if (i == 0) begin ip = 8'h07; im = 8'hff; ie = 1'b1; end
            if (vs == 5'h0) vs = 5'h1;
            apb(1'b1, VID_OFF_CTRL, {22'h0, vs, 5'h0});
            apb(1'b1, VID_OFF_CAUSE, {16'h0080, 6'h0, ip[1:0], 8'h0});
            apb(1'b1, VID_OFF_STATUS, {16'h0, im, 7'h0, ie});
            lvl_in <= ip[7:2];
            repeat (3) @(posedge core_clk);
            probe(4'h1, {31'h0, (|(ip & im)) & ie});
            for (j = 0; j < 8; j++) if (ip[j] & im[j]) v = j[2:0];
            if ((|(ip & im)) & ie) begin
                probe(4'h2, {29'h0, v});
                probe(4'h3, 32'h200 + v * {vs, 5'h0});
                apb(1'b1, VID_OFF_SSMAP, {25'h0, v, im[3:0]});
                @(posedge core_clk);
                exception_start <= 1'b1;
                @(posedge core_clk);
                exception_start <= 1'b0;
                probe(4'h6, {28'h0, im[3:0]});
            end
        end
        $display("Test vectored done");
        lvl_in <= 6'h0;
        ext_ctrl_mode_supported <= 1'b1;
        fw = $random(seed);
        {timer_request, perf_counter_request, debug_channel_request} <= fw;
        apb(1'b1, VID_OFF_CAUSE, 32'h0080_0200);
        probe(4'h0, VID_MODE_EXT);
        probe(4'h4, 32'h2);
        probe(4'h5, {29'h0, fw});
        {timer_request, perf_counter_request, debug_channel_request} <= 3'h0;
        for (i = 0; i < 6; i++) begin
            apb(1'b1, VID_OFF_STATUS, {16'h0, ps[i], 10'h001});
            lvl_in <= lvs[i]; set_in <= $random(seed); load <= 1'b1;
            @(posedge core_clk);
            load <= 1'b0;
            repeat (3) @(posedge core_clk);
            probe(4'h1, {31'h0, lvs[i] > ps[i]});
            if (lvs[i] > ps[i]) begin
                exp_q.push_back({4'h9, 26'h0, lvs[i]});
                exception_start <= 1'b1;
                @(posedge core_clk);
                exception_start <= 1'b0;
                repeat (3) @(posedge core_clk);
                probe(4'h6, {28'h0, set_in});
                rd(VID_OFF_CAUSE, {16'h0080, lvs[i], 10'h200}, 4'h7);
            end
        end
        $display("Test external done");
        apb(1'b1, VID_OFF_CTRL, 32'h0);
        probe(4'h0, VID_MODE_COMPAT);
        $display("Test fallback done");
        finish_test();
    end
endmodule : testbench

// ==== tb/vid_dispatch_asserts.sv ====
// Port assertions for the interrupt dispatch block
`timescale 1ns/1ns
module vid_dispatch_asserts
    import vid_pkg::*;
(
    input wire logic               core_clk,
    input wire logic               resetn,
    input wire logic [5:0]         hw_request_lines,
    input wire logic               timer_request,
    input wire logic               debug_channel_request,
    input wire logic               exception_start,
    input wire logic               irq_to_pipeline,
    input wire logic [5:0]         vector_number,
    input wire logic [15:0]        vector_offset,
    input wire logic [1:0]         soft_request_out,
    input wire logic               timer_request_out,
    input wire logic               debug_channel_request_out,
    input wire logic               service_ack,
    input wire vid_pkg::vid_mode_t irq_mode
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);

    mode_after_rst_a: assert property ($rose(resetn) |-> irq_mode == VID_MODE_COMPAT)
        else $error("mode not compatibility after reset");
    ack_single_a: assert property (service_ack |=> !service_ack)
        else $error("acknowledge longer than one cycle");
    ack_cause_a: assert property (exception_start && irq_to_pipeline && irq_mode == VID_MODE_EXT
        |=> service_ack && !irq_to_pipeline) else $error("entry not acknowledged");
    ack_only_a: assert property (service_ack |-> $past(exception_start) && $past(irq_to_pipeline))
        else $error("acknowledge without entry");
    requested_priority_level_vector_a: assert property (service_ack |-> vector_number == $past(hw_request_lines))
        else $error("vector differs from captured level");
    requested_priority_level_hold_a: assert property (irq_mode == VID_MODE_EXT && $past(irq_mode, 2) == VID_MODE_EXT
        && $past(irq_mode) == VID_MODE_EXT && !service_ack |-> $stable(vector_number))
        else $error("captured level changed without entry");
    soft_zero_a: assert property ((irq_mode != VID_MODE_EXT)[*2] |-> soft_request_out == 2'b00)
        else $error("soft requests forwarded outside external mode");
    fwd_copy_a: assert property (irq_mode == VID_MODE_EXT && $past(irq_mode) == VID_MODE_EXT
        |-> timer_request_out == $past(timer_request)
            && debug_channel_request_out == $past(debug_channel_request))
        else $error("forwarded request not a one-cycle copy");
    ext_zero_a: assert property (irq_mode == VID_MODE_EXT && $past(irq_mode) == VID_MODE_EXT
        && $past(hw_request_lines) == 6'h00 |-> !irq_to_pipeline) else $error("irq on level zero");
    compat_off_a: assert property ((irq_mode == VID_MODE_COMPAT)[*3]
        |-> vector_offset == VID_BASE_OFFSET) else $error("compat offset wrong");

    ack_c: cover property (service_ack);
    vec_c: cover property (irq_mode == VID_MODE_VEC && irq_to_pipeline);
    ext_c: cover property (irq_mode == VID_MODE_EXT && irq_to_pipeline);
endmodule : vid_dispatch_asserts

bind vid_dispatch vid_dispatch_asserts u_chk (.core_clk, .resetn, .hw_request_lines,
    .timer_request, .debug_channel_request, .exception_start, .irq_to_pipeline, .vector_number,
    .vector_offset, .soft_request_out, .timer_request_out, .debug_channel_request_out,
    .service_ack, .irq_mode);

// ==== tb/vid_eic_model.sv ====
// Behavioural external interrupt controller facing the dispatch block
`timescale 1ns/1ns
module vid_eic_model (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       ext_mode,
    input  wire logic       load,
    input  wire logic [5:0] lvl_in,
    input  wire logic [3:0] set_in,
    input  wire logic       service_ack,
    output logic      [5:0] hw_request_lines,
    output logic      [3:0] ext_supplied_shadow_set
);
    logic [5:0] lvl_r;
    logic [3:0] set_r;

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            lvl_r <= 6'h00;
            set_r <= 4'h0;
        end else if (load) begin
            lvl_r <= lvl_in;
            set_r <= set_in;
        end else if (service_ack) begin
            lvl_r <= 6'h00;
        end
    end

    // Held encoded level in external mode, raw lines otherwise
    assign hw_request_lines        = ext_mode ? lvl_r : lvl_in;
    // Set number is not held once the request is withdrawn
    assign ext_supplied_shadow_set = (lvl_r == 6'h00) ? ~set_r : set_r;
endmodule : vid_eic_model
